/* rtl/sadc_regs.svh */
// register offsets, field positions, reset values and timing counts
`ifndef SADC_REGS_SVH
`define SADC_REGS_SVH
`define SADC_OFS_CTRL 2'h0
`define SADC_OFS_RESULT 2'h1
`define SADC_OFS_STATUS 2'h2
`define SADC_OFS_MASK 2'h3
`define SADC_CTRL_CH_LSB 0
`define SADC_CTRL_DONE_BIT 3
`define SADC_CTRL_REFCON_BIT 4
`define SADC_CTRL_RESET 8'h08
`define SADC_STS_DONE_BIT 0
`define SADC_CONV_CYCLES 50
`define SADC_STEP_CYCLES 5
`define SADC_CLEAR_CYCLES 10
`endif

/* rtl/sadc_pkg.sv */
// types shared by the converter sequencer
package sadc_pkg;
  typedef enum logic [1:0] {
    SADC_IDLE,
    SADC_CLEAR,
    SADC_STEP
  } sadc_state_t;
endpackage

/* rtl/sadc_if.sv */
// link between sequencer core and its clock divider
`timescale 1ns/1ps
interface sadc_if;
  logic tick;
  logic restart;
  modport div (output tick, input restart);
  modport core (input tick, output restart);
endinterface

/* rtl/sadc_div.sv */
// divide-by-two enable for the converter operating clock
`timescale 1ns/1ps
module sadc_div (
  input wire logic MCLK, // main clock
  input wire logic RESET_N, // async reset, active low
  sadc_if.div lnk // tick out, restart in
);
  logic phase_reg;
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      phase_reg <= 1'b0;
    end else if (lnk.restart) begin
      phase_reg <= 1'b0;
    end else begin
      phase_reg <= ~phase_reg;
    end
  end
  assign lnk.tick = phase_reg;
endmodule // sadc_div

/* rtl/sadc_seq.sv */
// successive-approximation converter sequencer with register port
`timescale 1ns/1ps
`include "sadc_regs.svh"
module sadc_seq #(
  parameter int NUM_CH = 8 // 8 full variant, 4 small variant
) (
  input wire logic MCLK, // main clock, 40 MHz
  input wire logic RESET_N, // async reset, active low
  input wire logic [1:0] ADDR, // register address
  input wire logic [7:0] WDATA, // write data
  input wire logic WR, // write strobe
  input wire logic RD, // read strobe
  output logic [7:0] RDATA, // read data, cycle after read
  input wire logic CMP_OUT, // comparator: 1 when reference < input
  output logic [7:0] LADDER_CODE, // trial code to ladder
  output logic REF_CONNECT, // connect reference to ladder
  output logic [2:0] MUX_SEL, // analog input channel
  output logic CONV_BUSY, // conversion running
  output logic IRQ // level interrupt
);
  localparam int CNT_W = 6;
  localparam logic [CNT_W-1:0] STEP_LAST =
    CNT_W'(`SADC_STEP_CYCLES - 1);
  localparam logic [CNT_W-1:0] CLEAR_LAST =
    CNT_W'(`SADC_CLEAR_CYCLES - 1);
  localparam logic [2:0] CH_MASK = 3'(NUM_CH - 1);

  sadc_if lnk ();
  sadc_div u_div (
    .MCLK(MCLK),
    .RESET_N(RESET_N),
    .lnk(lnk)
  );

  sadc_pkg::sadc_state_t state_reg;
  logic [2:0] ch_reg;
  logic [2:0] ch_hold_reg;
  logic done_reg;
  logic refcon_reg;
  logic [7:0] result_reg;
  logic [2:0] bit_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic sts_reg;
  logic mask_reg;
  logic [7:0] rdata_reg;
  logic cmp_meta_reg;
  logic cmp_sync_reg;
  logic wr_ctrl;
  logic start;
  logic finish;
  logic [2:0] ch_wr;

  assign wr_ctrl = WR && (ADDR == `SADC_OFS_CTRL);
  assign start = wr_ctrl && !WDATA[`SADC_CTRL_DONE_BIT];
  assign lnk.restart = start;
  assign ch_wr = WDATA[`SADC_CTRL_CH_LSB +: 3] & CH_MASK;
  assign finish = (state_reg == sadc_pkg::SADC_STEP) && lnk.tick &&
    (cnt_reg == STEP_LAST) && (bit_reg == 3'h0);

  // comparator is analog, so it is synchronised before use
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      cmp_meta_reg <= 1'b0;
      cmp_sync_reg <= 1'b0;
    end else begin
      cmp_meta_reg <= CMP_OUT;
      cmp_sync_reg <= cmp_meta_reg;
    end
  end

  // control register fields
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ch_reg <= 3'h0;
      refcon_reg <= 1'b0;
    end else if (wr_ctrl) begin
      ch_reg <= ch_wr;
      refcon_reg <= WDATA[`SADC_CTRL_REFCON_BIT];
    end
  end

  // a start write wins over the hardware completion in the same cycle
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      done_reg <= 1'b1;
    end else if (start) begin
      done_reg <= 1'b0;
    end else if (finish) begin
      done_reg <= 1'b1;
    end
  end

  // sequencer: ten ticks of clear, then eight steps of five ticks
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state_reg <= sadc_pkg::SADC_IDLE;
      result_reg <= 8'h00;
      bit_reg <= 3'h7;
      cnt_reg <= '0;
      ch_hold_reg <= 3'h0;
    end else if (start) begin
      state_reg <= sadc_pkg::SADC_CLEAR;
      result_reg <= 8'h00;
      bit_reg <= 3'h7;
      cnt_reg <= '0;
      ch_hold_reg <= ch_wr;
    end else if (lnk.tick) begin
      unique case (state_reg)
        sadc_pkg::SADC_IDLE: begin
          cnt_reg <= '0;
        end
        sadc_pkg::SADC_CLEAR: begin
          if (cnt_reg == CLEAR_LAST) begin
            cnt_reg <= '0;
            state_reg <= sadc_pkg::SADC_STEP;
            result_reg[7] <= 1'b1;
          end else begin
            cnt_reg <= cnt_reg + CNT_W'(1);
          end
        end
        sadc_pkg::SADC_STEP: begin
          if (cnt_reg == STEP_LAST) begin
            cnt_reg <= '0;
            // sample taken after trial code settled all step long
            result_reg[bit_reg] <= cmp_sync_reg;
            if (bit_reg == 3'h0) begin
              state_reg <= sadc_pkg::SADC_IDLE;
            end else begin
              result_reg[bit_reg - 3'h1] <= 1'b1;
              bit_reg <= bit_reg - 3'h1;
            end
          end else begin
            cnt_reg <= cnt_reg + CNT_W'(1);
          end
        end
      endcase
    end
  end

  // interrupt status, write one to clear; a completion wins the clear
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      sts_reg <= 1'b0;
    end else if (finish) begin
      sts_reg <= 1'b1;
    end else if (WR && (ADDR == `SADC_OFS_STATUS) &&
                 WDATA[`SADC_STS_DONE_BIT]) begin
      sts_reg <= 1'b0;
    end
  end

  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      mask_reg <= 1'b0;
    end else if (WR && (ADDR == `SADC_OFS_MASK)) begin
      mask_reg <= WDATA[`SADC_STS_DONE_BIT];
    end
  end

  // register reads; the result offset has no write path
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rdata_reg <= 8'h00;
    end else if (RD) begin
      unique case (ADDR)
        `SADC_OFS_CTRL:
          rdata_reg <= {3'h0, refcon_reg, done_reg, ch_reg};
        `SADC_OFS_RESULT: rdata_reg <= result_reg;
        `SADC_OFS_STATUS: rdata_reg <= {7'h00, sts_reg};
        `SADC_OFS_MASK: rdata_reg <= {7'h00, mask_reg};
      endcase
    end else begin
      rdata_reg <= 8'h00;
    end
  end

  assign RDATA = rdata_reg;
  assign LADDER_CODE = result_reg;
  // without the reference the ladder draws no current
  assign REF_CONNECT = refcon_reg;
  assign MUX_SEL = ch_hold_reg;
  assign CONV_BUSY = (state_reg != sadc_pkg::SADC_IDLE);
  assign IRQ = sts_reg & mask_reg;
endmodule // sadc_seq

/* tb/sadc_cmp_model.sv */
// comparator, ladder and input multiplexer behind the sequencer
`timescale 1ns/1ps
module sadc_cmp_model (
  input wire logic [7:0] LADDER_CODE, // trial code
  input wire logic REF_CONNECT, // reference switch
  input wire logic [2:0] MUX_SEL, // channel
  output logic CMP_OUT // 1 when reference below input
);
  // input level per channel, in 256ths of the reference
  logic [7:0] analog_input_voltage [8];
  initial foreach (analog_input_voltage[i]) analog_input_voltage[i] = 8'h00;
  // ladder gives (n - 0.5)/256, so a trial stays while code <= input
  assign CMP_OUT = (REF_CONNECT ? LADDER_CODE : 8'h00)
    <= analog_input_voltage[MUX_SEL];
endmodule // sadc_cmp_model

/* tb/sadc_checker.sv */
// port assertions for the converter sequencer
`timescale 1ns/1ps
module sadc_checker (
  input wire logic MCLK, // clock
  input wire logic RESET_N, // reset, active low
  input wire logic [1:0] ADDR, // address
  input wire logic [7:0] WDATA, // write data
  input wire logic WR, // write strobe
  input wire logic [7:0] LADDER_CODE, // trial code
  input wire logic REF_CONNECT, // reference switch
  input wire logic [2:0] MUX_SEL, // channel
  input wire logic CONV_BUSY // converting
);
  logic st;
  logic [7:0] cnt_reg;
  assign st = WR && ADDR == 2'h0 && !WDATA[3];
  // a restart resets the count, so only whole runs are measured
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) cnt_reg <= 8'h00;
    else if (st) cnt_reg <= 8'h00;
    else if (CONV_BUSY) cnt_reg <= cnt_reg + 8'h01;
  end
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RESET_N);
  start_busy_a: assert property (st |=> CONV_BUSY
    && LADDER_CODE == 8'h00) else $error("start not taken");
  ladder_clear_a: assert property ($rose(CONV_BUSY)
    |-> (LADDER_CODE == 8'h00) [*8]) else $error("result not cleared");
  msb_trial_a: assert property ($rose(CONV_BUSY)
    |-> ##[18:24] LADDER_CODE == 8'h80) else $error("no bit 7 trial");
  conv_len_a: assert property ($fell(CONV_BUSY)
    |-> cnt_reg inside {[8'h63:8'h65]}) else $error("bad length");
  ref_follow_a: assert property (WR && ADDR == 2'h0
    |=> REF_CONNECT == $past(WDATA[4])) else $error("ref switch");
  mux_hold_a: assert property (CONV_BUSY && !$past(st)
    |-> $stable(MUX_SEL)) else $error("channel moved");
  result_ro_a: assert property (WR && ADDR == 2'h1 && !CONV_BUSY
    |=> $stable(LADDER_CODE)) else $error("result written");
  ladder_quiet_a: assert property ($changed(LADDER_CODE)
    |-> CONV_BUSY || $past(CONV_BUSY)) else $error("code moved idle");
endmodule // sadc_checker

/* tb/tb_top.sv */
// self-checking bench for the converter sequencer
`timescale 1ns/1ps
`include "sadc_regs.svh"
module tb_top;
  logic MCLK, RESET_N, WR, RD, cmp, ref_on, busy, irq;
  logic [1:0] ADDR;
  logic [7:0] WDATA, RDATA, code, d, e;
  logic [2:0] sel;
  int errors, n_compared;
  sadc_seq dut_u (.MCLK(MCLK), .RESET_N(RESET_N), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .CMP_OUT(cmp),
    .LADDER_CODE(code), .REF_CONNECT(ref_on), .MUX_SEL(sel),
    .CONV_BUSY(busy), .IRQ(irq));
  sadc_cmp_model cm_u (.LADDER_CODE(code), .REF_CONNECT(ref_on),
    .MUX_SEL(sel), .CMP_OUT(cmp));
  task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask
  task automatic wrap_up;
    $display("compared %0d, errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic wr(logic [1:0] a, logic [7:0] v);
    @(posedge MCLK);
    ADDR <= a;
    WDATA <= v;
    WR <= 1'b1;
    @(posedge MCLK);
    WR <= 1'b0;
  endtask
  task automatic rd(logic [1:0] a, output logic [7:0] v);
    @(posedge MCLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge MCLK);
    RD <= 1'b0;
    #1 v = RDATA;
  endtask
  function automatic logic [7:0] sar(logic [7:0] vi);
    logic [7:0] r;
    r = 8'h00;
    for (int b = 7; b >= 0; b--)
      if ((r | (8'h01 << b)) <= vi) r = r | (8'h01 << b);
    return r;
  endfunction
  // ref on, done bit cleared: a start on channel ch
  task automatic conv(logic [2:0] ch, logic [7:0] vi);
    logic [7:0] r;
    cm_u.analog_input_voltage[ch] = vi;
    wr(`SADC_OFS_CTRL, {3'h0, 2'b10, ch});
    @(posedge MCLK);
    #1 chk("busy", {7'h0, busy}, 8'h01);
    chk("mux", {5'h0, sel}, {5'h0, ch});
    for (int i = 0; i < 300 && busy !== 1'b0; i++) @(posedge MCLK);
    rd(`SADC_OFS_CTRL, r);
    chk("done", r & 8'h08, 8'h08);
    rd(`SADC_OFS_RESULT, r);
    chk("result", r, sar(vi));
  endtask
  initial begin
    MCLK = 1'b0;
    forever #12.5 MCLK = ~MCLK;
  end
  initial begin
    #500000;
    errors++;
    wrap_up;
  end
  initial begin
    {RESET_N, WR, RD, ADDR, WDATA} = '0;
    repeat (16) @(posedge MCLK);
    RESET_N <= 1'b1;
    rd(`SADC_OFS_CTRL, d);
    chk("ctrl", d, `SADC_CTRL_RESET);
    wr(`SADC_OFS_MASK, 8'h01);
    void'($urandom(32'heab4));
    conv(3'h0, 8'h00);
    conv(3'h7, 8'hff);
    for (int i = 0; i < 8; i++) conv(i[2:0], 8'($urandom));
    rd(`SADC_OFS_STATUS, d);
    chk("status", d, 8'h01);
    chk("irq", {7'h0, irq}, 8'h01);
    wr(`SADC_OFS_STATUS, 8'h01);
    @(posedge MCLK);
    #1 chk("irq", {7'h0, irq}, 8'h00);
    rd(`SADC_OFS_RESULT, e);
    wr(`SADC_OFS_RESULT, ~e);
    rd(`SADC_OFS_RESULT, d);
    chk("result", d, e);
    // restart part-way through: only the second level may show
    cm_u.analog_input_voltage[1] = 8'h20;
    wr(`SADC_OFS_CTRL, 8'h11);
    repeat (30) @(posedge MCLK);
    conv(3'h1, 8'hc5);
    wr(`SADC_OFS_STATUS, 8'h01);
    wr(`SADC_OFS_MASK, 8'h00);
    conv(3'h2, 8'h01);
    chk("irq", {7'h0, irq}, 8'h00);
    wr(`SADC_OFS_CTRL, 8'h08);
    @(posedge MCLK);
    #1 chk("ref", {7'h0, ref_on}, 8'h00);
    wrap_up;
  end
endmodule // tb_top
bind sadc_seq sadc_checker chk_u (.MCLK(MCLK), .RESET_N(RESET_N),
  .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .LADDER_CODE(LADDER_CODE),
  .REF_CONNECT(REF_CONNECT), .MUX_SEL(MUX_SEL), .CONV_BUSY(CONV_BUSY));
